// >>> bench/sdmr_ctl_model.sv
/*
 controller model that issues mode-register reads and writes.
 assumes the device answers a read on the cycle after it is taken.
*/
`timescale 1ns/1ns
`default_nettype none
module sdmr_ctl_model
(
   // clock and read answer
   input  wire logic       clk_i,
   input  wire logic [7:0] mrr_data_i,
   input  wire logic       mrr_valid_i,
   // commands
   output var  logic       mrw_o,
   output var  logic       mrr_o,
   output var  logic [7:0] ma_o,
   output var  logic [7:0] op_o
);
   logic [7:0] rd;
   logic       vld;

   initial
   begin
      mrw_o = 1'b0;
      mrr_o = 1'b0;
      ma_o  = 8'h00;
      op_o  = 8'h00;
   end

   // idle bus shows inverted data so a stale value never looks like a command
   task automatic cmd(input logic rw, input logic [7:0] ma,
                      input logic [7:0] op);
      @(negedge clk_i);
      mrr_o = rw;
      mrw_o = !rw;
      ma_o  = ma;
      op_o  = op;
      @(negedge clk_i);
      vld   = mrr_valid_i;
      rd    = mrr_data_i;
      mrr_o = 1'b0;
      mrw_o = 1'b0;
      ma_o  = ~ma;
      op_o  = ~op;
   endtask : cmd
endmodule : sdmr_ctl_model
`default_nettype wire

// >>> bench/tb.sv
/*
 self-checking bench for the mode-register block.
 assumes the controller model drives the command port at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   import sdmr_pkg::*;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic       init_done = 1'b0;
   logic       zq_done = 1'b0;
   logic       zq_hi = 1'b0;
   logic       zq_lo = 1'b0;
   logic       nwre = 1'b0;
   logic       bstart = 1'b0;
   logic       ce = 1'b1;
   logic [2:1] col = 2'h0;
   logic       mode_reg_write_cmd, mode_reg_read_cmd, rvalid, trim, cal_go, border, bact;
   logic [7:0] ma, op, rdata, cal_code;
   logic [2:0] blen, bcol;
   logic [4:0] wr;
   int         error_cnt = 0;
   int         cmp_count = 0;

   always #50 clk = ~clk;

   sdmr_ctl_model ctl (.clk_i(clk), .mrr_data_i(rdata), .mrr_valid_i(rvalid),
      .mrw_o(mode_reg_write_cmd), .mrr_o(mode_reg_read_cmd), .ma_o(ma), .op_o(op));

   sdmr_top dut (.CLOCK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
      .MRW_I(mode_reg_write_cmd), .MRR_I(mode_reg_read_cmd), .MA_I(ma), .OP_I(op),
      .MRR_DATA_O(rdata), .MRR_VALID_O(rvalid),
      .INIT_DONE_I(init_done), .ZQ_INIT_DONE_I(zq_done), .ZQ_HIGH_I(zq_hi),
      .ZQ_LOW_I(zq_lo), .NWRE_I(nwre), .FACTORY_TRIM_O(trim),
      .CAL_GO_O(cal_go), .CAL_CODE_O(cal_code), .BURST_LEN_O(blen),
      .BURST_ORDER_O(border), .WR_CYCLES_O(wr), .BURST_START_I(bstart),
      .COL_I(col), .BURST_ACTIVE_O(bact), .BURST_COL_O(bcol));

   task automatic chk(input string nm, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic summarize;
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      ctl.cmd(1'b1, a, 8'h00);
      chk("valid", ctl.vld, 1'b1);
      chk("data", ctl.rd, e);
   endtask : rd

   function automatic logic [7:0] info(input logic ini, input logic [1:0] st);
      return {LOWEST_LAT_SUPPORT, ALT_WL_SUPPORTED, 1'b0, st, 2'b00, ini};
   endfunction : info

   function automatic logic [4:0] wrdec(input logic x, input logic [2:0] c);
      case ({x, c})
         4'h1: return 5'h03;
         4'h7: return 5'h09;
         4'h4: return 5'h06;
         4'h6: return 5'h08;
         4'h8: return 5'h0A;
         4'h9: return 5'h0B;
         4'hA: return 5'h0C;
         4'hC: return 5'h0E;
         4'hE: return 5'h10;
         default: return 5'h00;
      endcase
   endfunction : wrdec

   initial
   begin
      #1000000;
      error_cnt++;
      summarize();
   end

   initial
   begin
      logic [1:0] st;
      logic [7:0] v;
      v = 8'($urandom(72));
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      rd(MA_DEVICE_INFO, info(1'b1, ST_UNSUPPORTED));
      init_done = 1'b1;
      ctl.cmd(1'b0, MA_DEVICE_INFO, 8'hFF);
      rd(MA_DEVICE_INFO, info(1'b0, ST_UNSUPPORTED));
      st = ST_UNSUPPORTED;
      for (int i = 0; i < 4; i++)
      begin
         zq_hi = i[1];
         zq_lo = i[0];
         rd(MA_DEVICE_INFO, info(1'b0, st));
         zq_done = 1'b1;
         @(negedge clk);
         zq_done = 1'b0;
         @(negedge clk);
         st = i[1] ? ST_PIN_HIGH : (i[0] ? ST_PIN_GND : ST_PASS);
         chk("trim", trim, i != 0);
         rd(MA_DEVICE_INFO, info(1'b0, st));
         v = 8'($urandom);
         ctl.cmd(1'b0, MA_CALIBRATION, v);
         chk("cal_go", cal_go, i == 0);
         if (i == 0)
            chk("cal_code", cal_code, v);
      end
      for (int i = 0; i < 24; i++)
      begin
         v = (i == 0) ? 8'h0B : 8'($urandom);
         nwre = 1'($urandom);
         ctl.cmd(1'b0, MA_DEVICE_FEATURE_ONE, v);
         chk("blen", blen, BURST_LEN_8);
         chk("order", border, v[FEAT_BURST_ORDER_BIT]);
         @(negedge clk);
         chk("wr", wr, wrdec(nwre, v[FEAT_WR_LO +: 3]));
      end
      rd(MA_DEVICE_FEATURE_ONE, 8'h00);
      rd(8'h05, 8'h00);
      // a second start mid-burst must not restart the column count
      for (int s = 0; s < 4; s++)
      begin
         col = 2'(s);
         bstart = 1'b1;
         @(negedge clk);
         for (int k = 0; k < 9; k++)
         begin
            chk("active", bact, k < 8);
            chk("col", bcol, k < 8 ? 3'(2 * s + k) : 3'h0);
            bstart = (k == 3);
            @(negedge clk);
         end
      end
      // a low enable must hold the burst where it stands
      col = 2'h1;
      bstart = 1'b1;
      @(negedge clk);
      bstart = 1'b0;
      ce = 1'b0;
      repeat (3) @(negedge clk);
      chk("ce_col", bcol, 3'h2);
      chk("ce_act", bact, 1'b1);
      ce = 1'b1;
      @(negedge clk);
      chk("ce_step", bcol, 3'h3);
      summarize();
   end
endmodule : tb
`default_nettype wire

// >>> common/sdmr_pkg.sv
/*
 mode-register package: addresses, field positions, reset values and codes
 for the device-information and first feature registers.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package sdmr_pkg;
   // register addresses on the mode-register command path
   localparam logic [7:0] MA_DEVICE_INFO        = 8'h00;
   localparam logic [7:0] MA_DEVICE_FEATURE_ONE = 8'h01;
   localparam logic [7:0] MA_CALIBRATION        = 8'h0A;

   // device_info field positions
   localparam int INFO_AUTO_INIT_BIT   = 0;
   localparam int INFO_SELFTEST_LO     = 3;
   localparam int INFO_ALT_WL_BIT      = 6;
   localparam int INFO_LOWEST_LAT_BIT  = 7;

   // device_feature_one field positions
   localparam int FEAT_BURST_LEN_LO    = 0;
   localparam int FEAT_BURST_ORDER_BIT = 3;
   localparam int FEAT_WR_LO           = 5;

   // self-test codes
   localparam logic [1:0] ST_UNSUPPORTED = 2'h0;
   localparam logic [1:0] ST_PIN_HIGH    = 2'h1;
   localparam logic [1:0] ST_PIN_GND     = 2'h2;
   localparam logic [1:0] ST_PASS        = 2'h3;

   // device options, fixed per die
   localparam logic SELFTEST_SUPPORTED = 1'b1;
   localparam logic ALT_WL_SUPPORTED   = 1'b1;
   localparam logic LOWEST_LAT_SUPPORT = 1'b0;

   // feature reset values and codes
   localparam logic [2:0] BURST_LEN_8     = 3'h3;
   localparam logic       BURST_ORDER_RST = 1'b0;
   localparam logic [2:0] WR_CODE_RST     = 3'h0;
   localparam logic [2:0] BURST_LAST      = 3'h7;

   // one-hot burst sequencer states
   typedef enum logic [1:0] {
      SDMR_IDLE  = 2'b01,
      SDMR_BURST = 2'b10
   } sdmr_burst_e;
endpackage : sdmr_pkg
`default_nettype wire

// >>> logic/sdmr_top.sv
/*
 mode-register logic for the device-information register (read only) and
 the first feature register (write only), plus burst column sequencing and
 calibration-command gating.
 assumes commands arrive already decoded, one per enabled clock, and that
 the extension bit of the second feature register comes in on a port.
*/
`timescale 1ns/1ns
`default_nettype none
module sdmr_top
(
   // clock, reset, enable
   input  wire  logic       CLOCK_I,
   input  wire  logic       ARST_N_I,
   input  wire  logic       CE_I,
   // mode-register commands
   input  wire  logic       MRW_I,
   input  wire  logic       MRR_I,
   input  wire  logic [7:0] MA_I,
   input  wire  logic [7:0] OP_I,
   output var   logic [7:0] MRR_DATA_O,
   output var   logic       MRR_VALID_O,
   // device core status
   input  wire  logic       INIT_DONE_I,
   input  wire  logic       ZQ_INIT_DONE_I,
   input  wire  logic       ZQ_HIGH_I,
   input  wire  logic       ZQ_LOW_I,
   input  wire  logic       NWRE_I,
   // calibration and driver control
   output var   logic       FACTORY_TRIM_O,
   output var   logic       CAL_GO_O,
   output var   logic [7:0] CAL_CODE_O,
   // feature outputs
   output var   logic [2:0] BURST_LEN_O,
   output var   logic       BURST_ORDER_O,
   output var   logic [4:0] WR_CYCLES_O,
   // burst column sequencer
   input  wire  logic       BURST_START_I,
   input  wire  logic [2:1] COL_I,
   output var   logic       BURST_ACTIVE_O,
   output var   logic [2:0] BURST_COL_O
);
   import sdmr_pkg::*;

   typedef struct packed {
      logic        auto_init_state;
      logic [1:0]  cal_resistor_selftest;
      logic [2:0]  burst_len;
      logic        burst_order;
      logic [2:0]  write_recovery_cycles;
      logic [4:0]  wr_cycles;
      logic [7:0]  mrr_data;
      logic        mrr_valid;
      logic        factory_trim;
      logic        cal_go;
      logic [7:0]  cal_code;
      sdmr_burst_e burst_state;
      logic [2:0]  burst_col;
      logic [2:0]  burst_cnt;
   } sdmr_state_s;

   sdmr_state_s s_q;
   sdmr_state_s s_d;
   logic        sync_1_q;
   logic        rst_n;

   // write-recovery decode; zero marks a reserved code
   function automatic logic [4:0] sdmr_wr_decode(input logic       ext,
                                                 input logic [2:0] code);
      logic [4:0] cyc;
      cyc = 5'h00;
      if (!ext)
      begin
         case (code)
            3'h1:    cyc = 5'h03;
            3'h4:    cyc = 5'h06;
            3'h6:    cyc = 5'h08;
            3'h7:    cyc = 5'h09;
            default: cyc = 5'h00;
         endcase
      end
      else
      begin
         case (code)
            3'h0:    cyc = 5'h0A;
            3'h1:    cyc = 5'h0B;
            3'h2:    cyc = 5'h0C;
            3'h4:    cyc = 5'h0E;
            3'h6:    cyc = 5'h10;
            default: cyc = 5'h00;
         endcase
      end
      return cyc;
   endfunction : sdmr_wr_decode

   function automatic logic sdmr_is_fault(input logic [1:0] st);
      return (st == ST_PIN_HIGH) || (st == ST_PIN_GND);
   endfunction : sdmr_is_fault

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLOCK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         sync_1_q <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         sync_1_q <= 1'b1;
         rst_n    <= sync_1_q;
      end
   end

   always_comb
   begin
      s_d           = s_q;
      // pulses clear only on enabled clocks so a frozen block holds them
      if (CE_I)
      begin
         s_d.mrr_valid       = 1'b0;
         s_d.cal_go          = 1'b0;
         s_d.auto_init_state = ~INIT_DONE_I;
         // code 11 only says a resistor was seen
         if (SELFTEST_SUPPORTED && ZQ_INIT_DONE_I)
         begin
            if (ZQ_HIGH_I)
               s_d.cal_resistor_selftest = ST_PIN_HIGH;
            else if (ZQ_LOW_I)
               s_d.cal_resistor_selftest = ST_PIN_GND;
            else
               s_d.cal_resistor_selftest = ST_PASS;
         end
         s_d.factory_trim = sdmr_is_fault(s_d.cal_resistor_selftest);
         if (MRR_I)
         begin
            s_d.mrr_valid = 1'b1;
            s_d.mrr_data  = 8'h00;
            // write-only registers read as zero rather than undefined
            if (MA_I == MA_DEVICE_INFO)
            begin
               s_d.mrr_data[INFO_AUTO_INIT_BIT] = s_q.auto_init_state;
               s_d.mrr_data[INFO_SELFTEST_LO +: 2] =
                  s_q.cal_resistor_selftest;
               s_d.mrr_data[INFO_ALT_WL_BIT] = ALT_WL_SUPPORTED;
               s_d.mrr_data[INFO_LOWEST_LAT_BIT] = LOWEST_LAT_SUPPORT;
            end
         end
         else if (MRW_I)
         begin
            // the read-only address falls through untouched
            if (MA_I == MA_DEVICE_FEATURE_ONE)
            begin
               // reserved burst lengths are not taken
               if (OP_I[FEAT_BURST_LEN_LO +: 3] == BURST_LEN_8)
                  s_d.burst_len = BURST_LEN_8;
               s_d.burst_order = OP_I[FEAT_BURST_ORDER_BIT];
               s_d.write_recovery_cycles = OP_I[FEAT_WR_LO +: 3];
            end
            else if (MA_I == MA_CALIBRATION && !s_q.factory_trim)
            begin
               s_d.cal_go   = 1'b1;
               s_d.cal_code = OP_I;
            end
         end
         s_d.wr_cycles = sdmr_wr_decode(NWRE_I,
                                        s_q.write_recovery_cycles);
         case (s_q.burst_state)
            SDMR_IDLE:
            begin
               if (BURST_START_I)
               begin
                  s_d.burst_state = SDMR_BURST;
                  s_d.burst_col   = {COL_I, 1'b0};
                  s_d.burst_cnt   = 3'h0;
               end
            end
            SDMR_BURST:
            begin
               s_d.burst_col = s_q.burst_col + 3'h1;
               s_d.burst_cnt = s_q.burst_cnt + 3'h1;
               if (s_q.burst_cnt == BURST_LAST)
               begin
                  s_d.burst_state = SDMR_IDLE;
                  s_d.burst_col   = 3'h0;
               end
            end
            default:
            begin
               s_d.burst_state = SDMR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q                       <= '0;
         s_q.auto_init_state       <= 1'b1;
         s_q.cal_resistor_selftest <= ST_UNSUPPORTED;
         s_q.burst_len             <= BURST_LEN_8;
         s_q.burst_order           <= BURST_ORDER_RST;
         s_q.write_recovery_cycles <= WR_CODE_RST;
         s_q.burst_state           <= SDMR_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign MRR_DATA_O     = s_q.mrr_data;
   assign MRR_VALID_O    = s_q.mrr_valid;
   assign FACTORY_TRIM_O = s_q.factory_trim;
   assign CAL_GO_O       = s_q.cal_go;
   assign CAL_CODE_O     = s_q.cal_code;
   assign BURST_LEN_O    = s_q.burst_len;
   assign BURST_ORDER_O  = s_q.burst_order;
   assign WR_CYCLES_O    = s_q.wr_cycles;
   assign BURST_ACTIVE_O = s_q.burst_state[1]; // one-hot burst bit
   assign BURST_COL_O    = s_q.burst_col;

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!rst_n);

   sequence s_burst_go;
      CE_I && BURST_START_I && s_q.burst_state == SDMR_IDLE;
   endsequence

   sequence s_wrap_step;
      CE_I && s_q.burst_state == SDMR_BURST;
   endsequence

   info_read_map_a: assert property (CE_I && MRR_I && MA_I == MA_DEVICE_INFO
      |=> MRR_VALID_O && MRR_DATA_O[0] == $past(s_q.auto_init_state)
          && MRR_DATA_O[6] == ALT_WL_SUPPORTED
          && MRR_DATA_O[7] == LOWEST_LAT_SUPPORT
          && MRR_DATA_O[5] == 1'b0)
      else $error("info register read mismatch");

   init_state_track_a: assert property (CE_I |=>
      s_q.auto_init_state == !$past(INIT_DONE_I))
      else $error("auto-init bit does not follow core");

   selftest_hold_a: assert property (!(CE_I && ZQ_INIT_DONE_I)
      |=> $stable(s_q.cal_resistor_selftest))
      else $error("self-test field changed without calibration");

   supply_tie_code_a: assert property (CE_I && ZQ_INIT_DONE_I && ZQ_HIGH_I
      |=> s_q.cal_resistor_selftest == ST_PIN_HIGH)
      else $error("supply-tied pin not coded 01");

   fault_blocks_cal_a: assert property (CE_I && MRW_I && !MRR_I
      && MA_I == MA_CALIBRATION && s_q.factory_trim |=> !CAL_GO_O)
      else $error("calibration taken during fault");

   fault_trim_a: assert property (CE_I && ZQ_INIT_DONE_I && ZQ_LOW_I
      && !ZQ_HIGH_I |=> ##1 FACTORY_TRIM_O)
      else $error("factory trim not forced on fault");

   ro_write_ignored_a: assert property (CE_I && MRW_I && !MRR_I
      && MA_I == MA_DEVICE_INFO |=> $stable(s_q.burst_len)
      && $stable(s_q.write_recovery_cycles) && !CAL_GO_O)
      else $error("read-only write changed state");

   wr_ext_decode_a: assert property (CE_I && NWRE_I
      && s_q.write_recovery_cycles == 3'h0 |=> WR_CYCLES_O == 5'h0A)
      else $error("extended write-recovery default wrong");

   burst_wrap_a: assert property (s_burst_go ##1 s_wrap_step
      |-> BURST_COL_O[0] == 1'b0 ##1
          BURST_COL_O == $past(BURST_COL_O) + 3'h1)
      else $error("burst column did not step");

   burst_length_a: assert property (s_burst_go ##1 CE_I [*8]
      |-> BURST_ACTIVE_O ##1 !BURST_ACTIVE_O)
      else $error("burst not eight beats long");
endmodule : sdmr_top
`default_nettype wire
